// file: rtl/e1fg_consts.vh
`ifndef E1FG_CONSTS_VH
`define E1FG_CONSTS_VH
// ======================================================================
// Register indexes within one channel; byte address = 4 * index
`define E1FG_CH_STRIDE 12'h100
`define E1FG_IDX_GEN_CTRL 8'h62
`define E1FG_IDX_SPARE_CTRL 8'h64
`define E1FG_IDX_SPARE7 8'h68
`define E1FG_IDX_SPARE8 8'h69
`define E1FG_IDX_EXTRA 8'h6a
`define E1FG_IDX_MAINT_A 8'h6b
`define E1FG_IDX_MAINT_B 8'h6c
`define E1FG_IDX_IRQ_EN 8'h6d
`define E1FG_IDX_FLAGS 8'h6e
// ======================================================================
// Field positions
`define E1FG_GEN_DISABLE 0
`define E1FG_GEN_CRC_EN 1
`define E1FG_GEN_SIG_EN 2
`define E1FG_GEN_EXTRA_REPLACE_DISABLE 6
`define E1FG_SP7_EN 1
`define E1FG_SP8_EN 0
`define E1FG_X0 3
`define E1FG_X1 1
`define E1FG_X2 0
`define E1FG_MA_REM 0
`define E1FG_MA_AUTO 1
`define E1FG_MA_CRIT 2
`define E1FG_MA_YBIT 3
`define E1FG_MA_TS16_ONES 4
`define E1FG_MA_TS16_ZERO 5
`define E1FG_MB_ONES 2
`define E1FG_MB_ZERO 3
`define E1FG_MB_SHIFT 4
`define E1FG_FL_BF 0
`define E1FG_FL_CRCMF 1
`define E1FG_FL_SIGMF 2
`define E1FG_FL_FAS 3
`define E1FG_FL_SUBMF 4
// ======================================================================
// Reset values and masks
`define E1FG_RST_GEN_CTRL 8'h00
`define E1FG_RST_SPARE_CTRL 2'h0
`define E1FG_RST_CODE 4'hf
`define E1FG_RST_EXTRA 3'h7
`define E1FG_RST_MAINT_A 6'h00
`define E1FG_RST_MAINT_B 3'h0
`define E1FG_RST_IRQ 5'h00
`define E1FG_FAS_WORD 7'h1b
// ======================================================================
// Timing
`define E1FG_CLK_HZ 100000000
`define E1FG_BIT_HZ 2048000
`define E1FG_BIT_DIV (`E1FG_CLK_HZ / `E1FG_BIT_HZ)
// Last divider count: 48 clocks per line bit
`define E1FG_BIT_DIV_LAST 8'h2f
`endif

// file: rtl/e1fg_top.v
// Summary of operation
// [RULE1] Spare-7 enable inserts code bit 3, or all four under CRC.
// [RULE2] Spare-8 enable inserts code bit 3, or all four under CRC.
// [RULE3] Signalling multiframe puts extra bits in TS16 frame 0 bits 5,7,8.
// [RULE4] TS16 zero force replaces every TS16 octet with zeros.
// [RULE5] TS16 ones force replaces every TS16 octet with ones.
// [RULE6] Y bit value sent in bit 6 of TS16 frame 0 under signalling multiframe.
// [RULE7] Criteria 0: frame loss, interworking, offline loss or manual.
// [RULE8] Criteria 1: frame loss or manual alarm only.
// [RULE9] Auto alarm enabled sends A bit one while criteria hold.
// [RULE10] Manual alarm sends A bit one unconditionally.
// [RULE11] A toggle of shift control, or several in one bit period, deletes or repeats one stream bit.
// [RULE12] Transmit zero force overwrites the whole stream with zeros.
// [RULE13] Transmit ones force overwrites the whole stream with ones.
// [RULE14] Sub-multiframe start sets flag bit 4; write one clears.
// [RULE15] Alignment word start sets flag bit 3; write one clears.
// [RULE16] Signalling multiframe start sets flag bit 2; write one clears.
// [RULE17] CRC multiframe start sets flag bit 1; write one clears.
// [RULE18] Basic frame start sets flag bit 0; write one clears.
// [RULE19] Each flag drives interrupt only while its enable bit is one.
// [RULE20] Extra-bit disable leaves extra bits unreplaced.
// [RULE21] Generation disable stops basic, CRC and signalling framing.
// [RULE22] Eight channel register copies, base at channel times 0x100.
// [RULE23] Whole-stream overwrites beat timeslot and bit insertions.
`timescale 1ns/1ps
`include "e1fg_consts.vh"

module e1fg_top (
  input wire clock,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [12:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [7:0] bp_data_i,
  input wire [7:0] rx_oof_i,
  input wire [7:0] rx_interwork_i,
  input wire [7:0] rx_offline_oof_i,
  output wire [7:0] line_data_o,
  output reg bit_tick_o,
  output wire irq_o
);

  // ====================================================================
  // Bit-rate enable
  // 100 MHz does not divide to 2.048 MHz; 48 clocks per bit runs slightly
  // fast, accepted since the true line clock belongs to the timing logic
  localparam [7:0] DIV_LAST = `E1FG_BIT_DIV_LAST;
  reg [7:0] div_q;
  wire tick = (div_q == DIV_LAST);

  always @(posedge clock) begin
    if (rst) begin
      div_q <= 8'h00;
      bit_tick_o <= 1'b0;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      bit_tick_o <= tick;
    end
  end

  // ====================================================================
  // Input synchronisers: three stages, accept when last two agree
  // Backplane data and receive status arrive from other clock domains
  wire [31:0] raw_in = {rx_offline_oof_i, rx_interwork_i, rx_oof_i,
    bp_data_i};
  wire [31:0] sync_in;

  genvar s;
  generate
    for (s = 0; s < 32; s = s + 1) begin : g_sync
      reg s1_q, s2_q, s3_q, val_q;
      always @(posedge clock) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          val_q <= 1'b0;
        end else begin
          s1_q <= raw_in[s];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            val_q <= s3_q;
          end
        end
      end
      assign sync_in[s] = val_q;
    end
  endgenerate

  // ====================================================================
  // Wishbone slave
  function is_mapped;
    input [7:0] off;
    begin
      is_mapped = (off == `E1FG_IDX_GEN_CTRL) ||
        (off == `E1FG_IDX_SPARE_CTRL) ||
        ((off >= `E1FG_IDX_SPARE7) && (off <= `E1FG_IDX_FLAGS));
    end
  endfunction

  wire [10:0] wb_idx = wb_adr_i[12:2];
  wire [2:0] wb_ch = wb_idx[10:8]; // see [RULE22]
  wire [7:0] wb_off = wb_idx[7:0];
  // Ack follows every strobe one cycle later, mapped or not, so a stray
  // access never hangs the bus; only byte lane 0 carries register data
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_go = req && wb_we_i && wb_sel_i[0] && is_mapped(wb_off);
  wire [63:0] rd_all;
  wire [7:0] irq_ch;

  always @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rd_all[wb_ch*8 +: 8]};
      end
    end
  end

  assign irq_o = |irq_ch;

  // ====================================================================
  // Per-channel registers and frame generator
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ch
      reg [7:0] gen_ctrl_q;
      reg [1:0] spare_ctrl_q;
      reg [3:0] sp7_q, sp8_q;
      reg [2:0] extra_q;
      reg [5:0] maint_a_q;
      reg [2:0] maint_b_q;
      reg [4:0] irq_en_q;
      reg [4:0] flags_q;
      reg [4:0] flags_d;
      reg shift_prev_q, shift_pend_q, shift_kind_q;
      reg [11:0] pos_q;
      reg line_q;
      reg gen_bit;
      reg [7:0] rd;
      wire ch_wr = wr_go && (wb_ch == g);
      wire [7:0] wd = wb_dat_i[7:0];
      wire in_bit = sync_in[g];
      wire rx_oof = sync_in[8 + g];
      wire rx_iw = sync_in[16 + g];
      wire rx_off = sync_in[24 + g];
      wire gen_on = !gen_ctrl_q[`E1FG_GEN_DISABLE]; // see [RULE21]
      wire crc_on = gen_on && gen_ctrl_q[`E1FG_GEN_CRC_EN];
      wire sig_on = gen_on && gen_ctrl_q[`E1FG_GEN_SIG_EN];
      wire extra_replace_disable = gen_ctrl_q[`E1FG_GEN_EXTRA_REPLACE_DISABLE];
      // Position fields: frame in the multiframe, timeslot, bit in octet
      wire [4:0] ts = pos_q[7:3];
      wire [2:0] bn = pos_q[2:0];
      wire [3:0] frm = pos_q[11:8];
      wire [1:0] code_sel = crc_on ? ~frm[2:1] : 2'h3;
      wire manual = maint_a_q[`E1FG_MA_REM];
      wire crit = maint_a_q[`E1FG_MA_CRIT] ? (rx_oof || manual) :
        (rx_oof || rx_iw || rx_off || manual); // see [RULE7] [RULE8]
      wire rai = manual ||
        (maint_a_q[`E1FG_MA_AUTO] && crit); // see [RULE9] [RULE10]
      wire shift_req = maint_b_q[2] ^ shift_prev_q;
      wire [4:0] ev;
      wire [7:0] fas_word = {1'b0, `E1FG_FAS_WORD};
      wire ts0_slot = (ts == 5'd0);
      wire ts16_slot = (ts == 5'd16);
      wire frame_start = (pos_q[7:0] == 8'h00);
      wire fas_start = (pos_q[7:0] == 8'h01);
      wire even_frame = !frm[0];
      reg ts0_bit;
      reg sig_bit;
      reg slot_bit;

      // ==================================================================
      // Boundary events
      // Seen as each bit enters the generator, so they set on the same tick
      // that the line output takes that bit
      assign ev[`E1FG_FL_BF] = gen_on && frame_start; // see [RULE18]
      assign ev[`E1FG_FL_CRCMF] = crc_on &&
        (pos_q == 12'h000); // see [RULE17]
      assign ev[`E1FG_FL_SIGMF] = sig_on &&
        (pos_q == 12'h000); // see [RULE16]
      assign ev[`E1FG_FL_FAS] = gen_on && even_frame &&
        fas_start; // see [RULE15]
      assign ev[`E1FG_FL_SUBMF] = crc_on && (frm[2:0] == 3'h0) &&
        frame_start; // see [RULE14]

      // ==================================================================
      // Timeslot 0: alignment word, A bit and spare bits
      always @* begin
        ts0_bit = in_bit;
        if (gen_on && ts0_slot) begin
          if (even_frame) begin
            // Bit 1 stays with the backplane; no international bit here
            if (bn != 3'd0) begin
              ts0_bit = fas_word[3'd7 - bn];
            end
          end else begin
            case (bn)
              3'd1: begin
                ts0_bit = 1'b1;
              end
              3'd2: begin
                ts0_bit = rai; // see [RULE9] [RULE10]
              end
              3'd6: begin
                if (spare_ctrl_q[`E1FG_SP7_EN]) begin
                  ts0_bit = sp7_q[code_sel]; // see [RULE1]
                end
              end
              3'd7: begin
                if (spare_ctrl_q[`E1FG_SP8_EN]) begin
                  ts0_bit = sp8_q[code_sel]; // see [RULE2]
                end
              end
              default: begin
                ts0_bit = in_bit;
              end
            endcase
          end
        end
      end

      // ==================================================================
      // Timeslot 16 of frame 0: alignment zeros, extra bits and Y bit
      always @* begin
        sig_bit = ts0_bit;
        if (sig_on && ts16_slot && frm == 4'h0) begin
          case (bn)
            3'd4: begin
              sig_bit = extra_replace_disable ? in_bit : extra_q[2]; // see [RULE3] [RULE20]
            end
            3'd5: begin
              sig_bit = maint_a_q[`E1FG_MA_YBIT]; // see [RULE6]
            end
            3'd6: begin
              sig_bit = extra_replace_disable ? in_bit : extra_q[1]; // see [RULE3] [RULE20]
            end
            3'd7: begin
              sig_bit = extra_replace_disable ? in_bit : extra_q[0]; // see [RULE3] [RULE20]
            end
            default: begin
              sig_bit = 1'b0;
            end
          endcase
        end
      end

      // ==================================================================
      // Timeslot 16 forcing; ones beats zeros when both are set
      always @* begin
        slot_bit = sig_bit;
        if (ts16_slot && maint_a_q[`E1FG_MA_TS16_ONES]) begin
          slot_bit = 1'b1; // see [RULE5]
        end else if (ts16_slot && maint_a_q[`E1FG_MA_TS16_ZERO]) begin
          slot_bit = 1'b0; // see [RULE4]
        end
      end

      // ==================================================================
      // Whole-stream overwrites come last so they beat any insertion;
      // zeros beats ones so a disabled port never sends alarm ones
      always @* begin
        gen_bit = slot_bit;
        if (maint_b_q[1]) begin
          gen_bit = 1'b0; // see [RULE12] [RULE23]
        end else if (maint_b_q[0]) begin
          gen_bit = 1'b1; // see [RULE13] [RULE23]
        end
      end

      // ==================================================================
      // Flags: set after clear so a coincident event survives
      always @* begin
        flags_d = flags_q;
        if (ch_wr && wb_off == `E1FG_IDX_FLAGS) begin
          flags_d = flags_q & ~wd[4:0];
        end
        if (tick) begin
          // see [RULE14] [RULE15] [RULE16] [RULE17] [RULE18]
          flags_d = flags_d | ev;
        end
      end

      // ==================================================================
      // Read-back; reserved bits read as zero
      always @* begin
        case (wb_off)
          `E1FG_IDX_GEN_CTRL: rd = gen_ctrl_q;
          `E1FG_IDX_SPARE_CTRL: rd = {6'h00, spare_ctrl_q};
          `E1FG_IDX_SPARE7: rd = {4'h0, sp7_q};
          `E1FG_IDX_SPARE8: rd = {4'h0, sp8_q};
          `E1FG_IDX_EXTRA: rd = {4'h0, extra_q[2], 1'b0, extra_q[1:0]};
          `E1FG_IDX_MAINT_A: rd = {2'h0, maint_a_q};
          `E1FG_IDX_MAINT_B: rd = {3'h0, maint_b_q, 2'h0};
          `E1FG_IDX_IRQ_EN: rd = {3'h0, irq_en_q};
          `E1FG_IDX_FLAGS: rd = {3'h0, flags_q};
          default: rd = 8'h00;
        endcase
      end

      always @(posedge clock) begin
        if (rst) begin
          gen_ctrl_q <= `E1FG_RST_GEN_CTRL;
          spare_ctrl_q <= `E1FG_RST_SPARE_CTRL;
          sp7_q <= `E1FG_RST_CODE;
          sp8_q <= `E1FG_RST_CODE;
          extra_q <= `E1FG_RST_EXTRA;
          maint_a_q <= `E1FG_RST_MAINT_A;
          maint_b_q <= `E1FG_RST_MAINT_B;
          irq_en_q <= `E1FG_RST_IRQ;
        // Flags are written through the clear path above
        end else if (ch_wr) begin // see [RULE22]
          case (wb_off)
            `E1FG_IDX_GEN_CTRL: gen_ctrl_q <= wd & 8'h47;
            `E1FG_IDX_SPARE_CTRL: spare_ctrl_q <= wd[1:0];
            `E1FG_IDX_SPARE7: sp7_q <= wd[3:0];
            `E1FG_IDX_SPARE8: sp8_q <= wd[3:0];
            `E1FG_IDX_EXTRA: extra_q <= {wd[`E1FG_X0], wd[`E1FG_X1],
              wd[`E1FG_X2]};
            `E1FG_IDX_MAINT_A: maint_a_q <= wd[5:0];
            `E1FG_IDX_MAINT_B: maint_b_q <= wd[4:2];
            `E1FG_IDX_IRQ_EN: irq_en_q <= wd[4:0];
            default: irq_en_q <= irq_en_q;
          endcase
        end
      end

      // ==================================================================
      // Alignment shift: toggles alternate a repeat (position held for
      // one bit) and a delete (position skips one bit); several toggles
      // between two ticks collapse into a single pending shift
      always @(posedge clock) begin
        if (rst) begin
          flags_q <= 5'h00;
          shift_prev_q <= 1'b0;
          shift_pend_q <= 1'b0;
          shift_kind_q <= 1'b0;
          pos_q <= 12'h000;
          line_q <= 1'b0;
        end else begin
          flags_q <= flags_d;
          shift_prev_q <= maint_b_q[2];
          if (tick) begin
            line_q <= gen_bit;
            if (shift_pend_q) begin
              shift_pend_q <= shift_req;
              shift_kind_q <= !shift_kind_q;
              pos_q <= shift_kind_q ? pos_q + 12'h002 : pos_q; // see [RULE11]
            end else begin
              shift_pend_q <= shift_req;
              pos_q <= pos_q + 12'h001;
            end
          end else if (shift_req) begin
            shift_pend_q <= 1'b1;
          end
        end
      end

      assign line_data_o[g] = line_q;
      assign rd_all[g*8 +: 8] = rd;
      assign irq_ch[g] = |(flags_q & irq_en_q); // see [RULE19]
    end
  endgenerate

endmodule // e1fg_top

// file: verification/e1fg_checker.sv
`timescale 1ns/1ps
// ======
// Handshake and stream cadence
module e1fg_checker (
  input wire clock,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [7:0] line_data_o,
  input wire bit_tick_o,
  input wire irq_o
);
  reg [7:0] gap_q;
  reg seen_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // One line bit lasts 48 clocks
  always @(posedge clock) begin
    gap_q <= (rst || bit_tick_o) ? 8'h00 : gap_q + 8'h01;
    seen_q <= !rst && (seen_q || bit_tick_o);
  end
  a_ack_next: assert property (s_req |=> s_ack)
    else $error("no ack pulse");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("stray ack");
  a_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read high bits set");
  a_tick_pulse: assert property (bit_tick_o |=> !bit_tick_o [*8])
    else $error("tick too wide");
  a_tick_gap: assert property (bit_tick_o && seen_q |-> gap_q == 8'h2f)
    else $error("tick spacing");
  a_tick_due: assert property (seen_q |-> gap_q < 8'h30)
    else $error("tick missing");
  a_line_hold: assert property (!bit_tick_o |-> $stable(line_data_o))
    else $error("line moved off tick");
  a_quiet_start: assert property ($fell(rst) |-> !irq_o)
    else $error("irq after reset");
endmodule // e1fg_checker

bind e1fg_top e1fg_checker e1fg_checker_inst (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .line_data_o(line_data_o),
  .bit_tick_o(bit_tick_o), .irq_o(irq_o));

// file: verification/e1fg_partner.sv
`timescale 1ns/1ps
// ======
// Backplane source and line monitor
module e1fg_partner (
  input wire clock,
  input wire rst,
  input wire clr,
  input wire bit_tick_o,
  input wire [7:0] line_data_o,
  output reg [7:0] bp_q,
  output reg [11:0] pos_q,
  output reg [15:0] ts0_q,
  output reg [7:0] ts16_q,
  output reg [31:0] mon_q
);
  // Payload flips every bit so a forced level stands out
  always @(posedge clock) begin
    if (rst) begin
      bp_q <= 8'h55;
      pos_q <= 12'h000;
    end else if (bit_tick_o) begin
      bp_q <= ~bp_q;
      pos_q <= pos_q + 12'h001;
      if (pos_q[7:3] == 5'h00)
        ts0_q[{pos_q[8], ~pos_q[2:0]}] <= line_data_o[0];
      if (pos_q[11:3] == 9'h010)
        ts16_q[~pos_q[2:0]] <= line_data_o[1];
      if (pos_q[7:3] == 5'h10) begin
        mon_q[31:24] <= mon_q[31:24] & line_data_o;
        mon_q[23:16] <= mon_q[23:16] | line_data_o;
      end
      mon_q[15:8] <= mon_q[15:8] & line_data_o;
      mon_q[7:0] <= mon_q[7:0] | line_data_o;
    end
    if (rst || clr)
      mon_q <= 32'hff00ff00;
  end
endmodule // e1fg_partner

// file: verification/e1fg_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
  n_mismatch++; end end
// ======
// Bus driver and test sequence
module e1fg_top_bench;
  reg clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg clr = 1'b0;
  reg [12:0] adr = 13'h0;
  reg [31:0] wd = 32'h0, r;
  reg [3:0] sel = 4'h0;
  reg [7:0] iw = 8'h00;
  wire [31:0] rd, mon;
  wire ack, tick, irq;
  wire [7:0] bp, line, ts16;
  wire [11:0] pos;
  wire [15:0] ts0;
  integer n_mismatch = 0, check_count = 0, i;
  reg [15:0] rt [0:5] = '{16'h680f, 16'h690f, 16'h6a0b, 16'h6b00,
    16'h6c00, 16'h6d00};
  // Rows: channel, index, data
  reg [19:0] st [0:8] = '{20'h26b10, 20'h36b20, 20'h46c04, 20'h56c0c,
    20'h66b10, 20'h66c08, 20'h06403, 20'h06808, 20'h06907};
  // Channel 1: CRC and signalling framing, extra bits, Y bit
  reg [15:0] cf [0:2] = '{16'h6206, 16'h6a0a, 16'h6b08};
  // Rows: alarm control, interworking status
  reg [15:0] al [0:2] = '{16'h0100, 16'h06ff, 16'h02ff};
  reg [2:0] aex = 3'b101;
  initial forever #5 clock = ~clock;
  e1fg_top e1fg_top_inst (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .bp_data_i(bp),
    .rx_oof_i(8'h00), .rx_interwork_i(iw), .rx_offline_oof_i(8'h00),
    .line_data_o(line), .bit_tick_o(tick), .irq_o(irq));
  e1fg_partner e1fg_partner_inst (.clock(clock), .rst(rst), .clr(clr),
    .bit_tick_o(tick), .line_data_o(line), .bp_q(bp), .pos_q(pos),
    .ts0_q(ts0), .ts16_q(ts16), .mon_q(mon));
  task end_sim;
    begin
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task xfer(input w, input [2:0] ch, input [7:0] ix, input [7:0] d);
    integer k;
    begin
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h1;
      adr <= {ch, ix, 2'b00};
      wd <= {24'h0, d};
      @(posedge clock);
      for (k = 0; ack !== 1'b1 && k < 50; k++) @(posedge clock);
      if (k == 50) n_mismatch++;
      r = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // Frame position as counted from line ticks
  task wait_pos(input [8:0] p);
    integer k;
    begin
      for (k = 0; pos[8:0] !== p && k < 30000; k++) @(posedge clock);
      if (k == 30000) n_mismatch++;
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // Before the first bit tick, so the first frame is already framed
    for (i = 0; i < 3; i++)
      xfer(1'b1, 3'h1, cf[i][15:8], cf[i][7:0]);
    for (i = 0; i < 6; i++) begin
      xfer(1'b0, 3'h7, rt[i][15:8], 8'h00);
      `CHK(r, {24'h0, rt[i][7:0]})
    end
    xfer(1'b1, 3'h3, 8'h68, 8'ha5);
    xfer(1'b1, 3'h7, 8'h6c, 8'hff);
    xfer(1'b0, 3'h3, 8'h68, 8'h00);
    `CHK(r, 32'h05)
    xfer(1'b0, 3'h2, 8'h68, 8'h00);
    `CHK(r, 32'h0f)
    xfer(1'b0, 3'h7, 8'h6c, 8'h00);
    `CHK(r, 32'h1c)
    xfer(1'b0, 3'h0, 8'h00, 8'h00);
    `CHK(r, 32'h00)
    `CHK(irq, 1'b0)
    $display("Test registers done");
    wait_pos(9'h088);
    `CHK(ts16, 8'h0e)
    xfer(1'b0, 3'h1, 8'h6e, 8'h00);
    `CHK(r, 32'h1f)
    $display("Test signalling done");
    for (i = 0; i < 9; i++)
      xfer(1'b1, st[i][18:16], st[i][15:8], st[i][7:0]);
    xfer(1'b1, 3'h0, 8'h6e, 8'h1f);
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, 3'h0, 8'h6b, al[i][15:8]);
      iw <= al[i][7:0];
      wait_pos(9'h100);
      wait_pos(9'h108);
      `CHK(ts0[13], aex[i])
      `CHK({ts0[14], ts0[6:0]}, 8'h9b)
      `CHK({ts0[9], ts0[8]}, 2'b10)
      if (i == 0) begin
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
      end
    end
    `CHK({mon[26], mon[19], mon[12], mon[5], mon[6], mon[8], mon[0]},
      7'h51)
    $display("Test stream done");
    xfer(1'b0, 3'h0, 8'h6e, 8'h00);
    `CHK(r, 32'h09)
    xfer(1'b1, 3'h0, 8'h6d, 8'h01);
    `CHK(irq, 1'b1)
    xfer(1'b1, 3'h0, 8'h6e, 8'h01);
    `CHK(irq, 1'b0)
    xfer(1'b0, 3'h0, 8'h6e, 8'h00);
    `CHK(r, 32'h08)
    xfer(1'b1, 3'h0, 8'h62, 8'h01);
    xfer(1'b1, 3'h0, 8'h6e, 8'h1f);
    wait_pos(9'h001);
    xfer(1'b0, 3'h0, 8'h6e, 8'h00);
    `CHK(r, 32'h00)
    $display("Test flags done");
    end_sim;
  end
  // About 75k clocks expected; stop short of the 100k cycle budget
  initial begin
    #950000;
    n_mismatch++;
    end_sim;
  end
endmodule // e1fg_top_bench
